// ==== common/pced_pkg.sv ====
package pced_pkg;
    typedef logic [7:0] pced_byte_t;
    typedef logic [3:0] pced_addr_t;
endpackage

// ==== common/pced_regs.svh ====
`ifndef PCED_REGS_SVH
`define PCED_REGS_SVH

// register offsets on the plain register port
`define PCED_ADDR_W          4
`define PCED_OFS_PA_RISE     4'h0
`define PCED_OFS_PA_FALL     4'h1
`define PCED_OFS_PA_FLAGS    4'h2
`define PCED_OFS_PB_RISE     4'h3
`define PCED_OFS_PB_FALL     4'h4
`define PCED_OFS_PB_FLAGS    4'h5
`define PCED_OFS_CTRL        4'h6
`define PCED_OFS_IRQ_STATUS  4'h7
`define PCED_OFS_IRQ_MASK    4'h8

// implemented bit masks
`define PCED_PA_MASK         8'h3f
`define PCED_PB_MASK         8'hf0
`define PCED_PA_LSB          0
`define PCED_PA_MSB          5
`define PCED_PB_LSB          4
`define PCED_PB_MSB          7

// control and interrupt fields
`define PCED_CTRL_MIE_BIT    0
`define PCED_IRQ_PA_BIT      0
`define PCED_IRQ_PB_BIT      1
`define PCED_IRQ_MASK        8'h03

`define PCED_RESET_VAL       8'h00

`endif

// ==== src/pced_top.sv ====
// How it works
// - port A rising enables at bits 5..0
// - port A falling enables at bits 5..0
// - enabled port A edge sets its flag
// - flag-setting edge also sets shared flag
// - flags read back their state; software writes zero clears
// - port A bits 7..6 read zero
// - port B rising enables at bits 7..4
// - port B falling enables at bits 7..4
// - enabled port B edge sets its flag
// - port B bits 3..0 read zero
// - all enables and flags reset to zero
// - flags software writable, hardware settable too
// - port B slice removable by parameter
// - detection continues with master enable clear
// - edge during clear leaves flag set
// - shared flag is OR of all flags
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "pced_regs.svh"

// one pin: synchroniser, previous sample and armed edge compare
module pced_pin_cell #(
    parameter int SYNC_STAGES = 2
) (
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic pin_i,
    input  wire logic rise_en_i,
    input  wire logic fall_en_i,
    output logic      hit_o
);
    logic [SYNC_STAGES-1:0] sync;
    logic                   prev;
    logic                   level;
    logic                   rose;
    logic                   fell;

    // fewer than two stages would compare a possibly unsettled sample
    if (SYNC_STAGES < 2)
    begin : g_bad_depth
        $error("SYNC_STAGES must be at least 2");
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sync <= {SYNC_STAGES{1'b0}};
            prev <= 1'b0;
        end
        else
        begin
            sync <= {sync[SYNC_STAGES-2:0], pin_i};
            prev <= sync[SYNC_STAGES-1];
        end
    end

    // only the last stage is compared; earlier stages may still be settling
    assign level = sync[SYNC_STAGES-1];
    assign rose  = level & ~prev;
    assign fell  = ~level & prev;
    assign hit_o = (rose & rise_en_i) | (fell & fall_en_i);
endmodule // pced_pin_cell

module pced_top #(
    parameter bit HAS_PORT_B = 1'b1
) (
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    input  wire logic [5:0]       port_a_pin_i,
    input  wire logic [7:4]       port_b_pin_i,
    input  wire pced_pkg::pced_addr_t addr_i,
    input  wire pced_pkg::pced_byte_t wdata_i,
    input  wire logic             wr_i,
    input  wire logic             rd_i,
    output logic [7:0]            rdata_o,
    output logic                  shared_change_flag_o,
    output logic                  irq_o
);
    import pced_pkg::*;

    // the slices must match the pin ports they are fed from
    if (`PCED_PA_MSB - `PCED_PA_LSB + 1 != $bits(port_a_pin_i))
    begin : g_bad_port_a
        $error("port A slice does not match its pins");
    end
    if (`PCED_PB_MSB - `PCED_PB_LSB + 1 != $bits(port_b_pin_i))
    begin : g_bad_port_b
        $error("port B slice does not match its pins");
    end

    // absent port B pins are tied off and never produce an edge
    pced_byte_t impl_b;
    pced_byte_t edge_a;
    pced_byte_t edge_b;

    assign impl_b = HAS_PORT_B ? `PCED_PB_MASK : 8'h00;

    // software-visible registers
    pced_byte_t porta_rise_enable;
    pced_byte_t porta_fall_enable;
    pced_byte_t porta_change_flags;
    pced_byte_t portb_rise_enable;
    pced_byte_t portb_fall_enable;
    pced_byte_t portb_change_flags;
    logic       change_interrupt_master_enable;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    pced_byte_t next_porta_change_flags;
    pced_byte_t next_portb_change_flags;
    logic [1:0] next_status;
    logic       next_master_enable;
    logic [1:0] next_irq_mask;
    logic       next_irq;

    // one cell per implemented pin
    for (genvar i = `PCED_PA_LSB; i <= `PCED_PA_MSB; i++)
    begin : g_pin_a
        pced_pin_cell u_cell (
            .clk_i     (clk_i),
            .arst_n_i  (arst_n_i),
            .pin_i     (port_a_pin_i[i]),
            .rise_en_i (porta_rise_enable[i]),
            .fall_en_i (porta_fall_enable[i]),
            .hit_o     (edge_a[i])
        );
    end
    assign edge_a[7:6] = 2'b00;

    if (HAS_PORT_B)
    begin : g_port_b
        for (genvar j = `PCED_PB_LSB; j <= `PCED_PB_MSB; j++)
        begin : g_pin_b
            pced_pin_cell u_cell (
                .clk_i     (clk_i),
                .arst_n_i  (arst_n_i),
                .pin_i     (port_b_pin_i[j]),
                .rise_en_i (portb_rise_enable[j]),
                .fall_en_i (portb_fall_enable[j]),
                .hit_o     (edge_b[j])
            );
        end
    end
    else
    begin : g_no_port_b
        assign edge_b[7:4] = 4'h0;
    end
    assign edge_b[3:0] = 4'h0;

    logic wr_pa_r;
    logic wr_pa_f;
    logic wr_pa_x;
    logic wr_pb_r;
    logic wr_pb_f;
    logic wr_pb_x;
    logic wr_ctl;
    logic wr_ist;
    logic wr_imk;

    // one write select per register; unmapped offsets select nothing
    always_comb
    begin
        wr_pa_r = 1'b0;
        wr_pa_f = 1'b0;
        wr_pa_x = 1'b0;
        wr_pb_r = 1'b0;
        wr_pb_f = 1'b0;
        wr_pb_x = 1'b0;
        wr_ctl  = 1'b0;
        wr_ist  = 1'b0;
        wr_imk  = 1'b0;
        if (wr_i)
        begin
            case (addr_i)
                `PCED_OFS_PA_RISE:    wr_pa_r = 1'b1;
                `PCED_OFS_PA_FALL:    wr_pa_f = 1'b1;
                `PCED_OFS_PA_FLAGS:   wr_pa_x = 1'b1;
                `PCED_OFS_PB_RISE:    wr_pb_r = 1'b1;
                `PCED_OFS_PB_FALL:    wr_pb_f = 1'b1;
                `PCED_OFS_PB_FLAGS:   wr_pb_x = 1'b1;
                `PCED_OFS_CTRL:       wr_ctl  = 1'b1;
                `PCED_OFS_IRQ_STATUS: wr_ist  = 1'b1;
                `PCED_OFS_IRQ_MASK:   wr_imk  = 1'b1;
                default:              wr_pa_r = 1'b0;
            endcase
        end
    end

    // port A enables; the upper two bits do not exist
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            porta_rise_enable <= `PCED_RESET_VAL;
            porta_fall_enable <= `PCED_RESET_VAL;
        end
        else
        begin
            if (wr_pa_r)
                porta_rise_enable <= wdata_i & `PCED_PA_MASK;
            if (wr_pa_f)
                porta_fall_enable <= wdata_i & `PCED_PA_MASK;
        end
    end

    // port B enables; the lower four bits do not exist
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            portb_rise_enable <= `PCED_RESET_VAL;
            portb_fall_enable <= `PCED_RESET_VAL;
        end
        else
        begin
            if (wr_pb_r)
                portb_rise_enable <= wdata_i & impl_b;
            if (wr_pb_f)
                portb_fall_enable <= wdata_i & impl_b;
        end
    end

    // master enable only withholds the interrupt request
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            change_interrupt_master_enable <= 1'b0;
        else
            change_interrupt_master_enable <= next_master_enable;
    end

    // flag next values; a detected edge wins over a clear in the same cycle
    always_comb
    begin
        next_porta_change_flags = porta_change_flags;
        next_portb_change_flags = portb_change_flags;
        if (wr_pa_x)
            next_porta_change_flags = wdata_i;
        if (wr_pb_x)
            next_portb_change_flags = wdata_i;
        next_porta_change_flags = (next_porta_change_flags & `PCED_PA_MASK)
                                | edge_a;
        next_portb_change_flags = (next_portb_change_flags & impl_b)
                                | edge_b;
    end

    // interrupt side: sticky status with set winning, mask, master enable
    always_comb
    begin
        next_status        = irq_status & ~({2{wr_ist}} & wdata_i[1:0]);
        next_master_enable = change_interrupt_master_enable;
        next_irq_mask      = irq_mask;
        if (wr_ctl)
            next_master_enable = wdata_i[`PCED_CTRL_MIE_BIT];
        if (wr_imk)
            next_irq_mask = wdata_i[1:0];
        next_status[`PCED_IRQ_PA_BIT] = next_status[`PCED_IRQ_PA_BIT] | (|edge_a);
        next_status[`PCED_IRQ_PB_BIT] = next_status[`PCED_IRQ_PB_BIT] | (|edge_b);
        next_irq = next_master_enable & (|(next_status & next_irq_mask));
    end

    // port A flags
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            porta_change_flags <= `PCED_RESET_VAL;
        else
            porta_change_flags <= next_porta_change_flags;
    end

    // port B flags
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            portb_change_flags <= `PCED_RESET_VAL;
        else
            portb_change_flags <= next_portb_change_flags;
    end

    // shared flag: registered OR of every per-pin flag, so it never lags them
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            shared_change_flag_o <= 1'b0;
        else
            shared_change_flag_o <= |(next_porta_change_flags
                                      | next_portb_change_flags);
    end

    // sticky event status, write one to clear; set wins
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            irq_status <= 2'b00;
        else
            irq_status <= next_status;
    end

    // interrupt mask, same layout as the status
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            irq_mask <= 2'b00;
        else
            irq_mask <= next_irq_mask;
    end

    // interrupt withheld without master enable; detection itself unaffected
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            irq_o <= 1'b0;
        else
            irq_o <= next_irq;
    end

    // read data one cycle after read strobe, zero otherwise
    pced_byte_t rd_mux;
    always_comb
    begin
        case (addr_i)
            `PCED_OFS_PA_RISE:   rd_mux = porta_rise_enable;
            `PCED_OFS_PA_FALL:   rd_mux = porta_fall_enable;
            `PCED_OFS_PA_FLAGS:  rd_mux = porta_change_flags;
            `PCED_OFS_PB_RISE:   rd_mux = portb_rise_enable;
            `PCED_OFS_PB_FALL:   rd_mux = portb_fall_enable;
            `PCED_OFS_PB_FLAGS:  rd_mux = portb_change_flags;
            `PCED_OFS_CTRL:      rd_mux = {7'h00, change_interrupt_master_enable};
            `PCED_OFS_IRQ_STATUS: rd_mux = {6'h00, irq_status};
            `PCED_OFS_IRQ_MASK:  rd_mux = {6'h00, irq_mask};
            default:             rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rdata_o <= 8'h00;
        else
            rdata_o <= rd_i ? rd_mux : 8'h00;
    end

endmodule // pced_top

// ==== verification/pced_pins.sv ====
`timescale 1ns/1ps
module pced_pins (
    input  wire logic  clk_i,
    output logic [5:0] port_a_pin_o,
    output logic [7:4] port_b_pin_o
);
    initial
    begin
        port_a_pin_o = 6'h00;
        port_b_pin_o = 4'h0;
    end
    // board levels move just after a clock edge and then stay put
    task automatic drive(input logic [5:0] a, input logic [3:0] b);
        @(posedge clk_i);
        port_a_pin_o <= a;
        port_b_pin_o <= b;
    endtask
endmodule // pced_pins

// ==== verification/pced_properties.sv ====
`timescale 1ns/1ps
module pced_properties (
    input wire logic                 clk_i,
    input wire logic                 arst_n_i,
    input wire logic [5:0]           port_a_pin_i,
    input wire logic [7:4]           port_b_pin_i,
    input wire pced_pkg::pced_addr_t addr_i,
    input wire pced_pkg::pced_byte_t wdata_i,
    input wire logic                 wr_i,
    input wire logic                 rd_i,
    input wire logic [7:0]           rdata_o,
    input wire logic                 shared_change_flag_o,
    input wire logic                 irq_o
);
    logic mie;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // shadow of the master enable, seen from the register writes
    always_ff @(posedge clk_i or negedge arst_n_i)
        if (!arst_n_i)
            mie <= 1'b0;
        else if (wr_i && addr_i == 4'h6)
            mie <= wdata_i[0];
    sequence s_rd_pa;
        rd_i && addr_i <= 4'h2;
    endsequence
    sequence s_rd_pb;
        rd_i && addr_i inside {[4'h3:4'h5]};
    endsequence
    a_pa_high_zero: assert property (s_rd_pa |=> rdata_o[7:6] == 2'b00)
        else $error("port A upper bits not zero");
    a_pb_low_zero: assert property (s_rd_pb |=> rdata_o[3:0] == 4'h0)
        else $error("port B lower bits not zero");
    a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read answer");
    a_reset_clear: assert property (disable iff (1'b0) !arst_n_i |->
        rdata_o == 8'h00 && !shared_change_flag_o && !irq_o) else $error("reset not clear");
    a_flag_cause: assert property ($rose(shared_change_flag_o) |->
        $past(wr_i) || $past(wr_i, 2) || $past(port_a_pin_i, 3) != $past(port_a_pin_i, 2)
        || $past(port_a_pin_i, 4) != $past(port_a_pin_i, 3)
        || $past(port_b_pin_i, 3) != $past(port_b_pin_i, 2)
        || $past(port_b_pin_i, 4) != $past(port_b_pin_i, 3)) else $error("flag without cause");
    a_flag_hold: assert property ($fell(shared_change_flag_o) |->
        $past(wr_i) || $past(wr_i, 2)) else $error("flag dropped without write");
    a_irq_sticky: assert property ($fell(irq_o) |-> $past(wr_i) || $past(wr_i, 2))
        else $error("interrupt dropped without write");
    a_irq_gated: assert property (!mie && !$past(mie) |-> !irq_o)
        else $error("interrupt with master enable clear");
endmodule // pced_properties

// ==== verification/tb_pin_change_edge_detector.sv ====
`timescale 1ns/1ps
module tb_pin_change_edge_detector;
    import pced_pkg::*;
    logic       clk_i = 1'b0;
    logic       arst_n_i = 1'b0;
    logic [5:0] pa;
    logic [7:4] pb;
    pced_addr_t addr_i = 4'h0;
    pced_byte_t wdata_i = 8'h00;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic       shared_change_flag_o;
    logic       irq_o;
    logic [7:0] rdata_nob;
    logic       flag_nob;
    logic       irq_nob;
    int         fails = 0;
    int         checks = 0;
    initial forever #4 clk_i = ~clk_i;
    pced_pins pins (.clk_i(clk_i), .port_a_pin_o(pa), .port_b_pin_o(pb));
    pced_top dut (.clk_i, .arst_n_i, .port_a_pin_i(pa), .port_b_pin_i(pb), .addr_i, .wdata_i,
        .wr_i, .rd_i, .rdata_o, .shared_change_flag_o, .irq_o);
    pced_top #(.HAS_PORT_B(1'b0)) dut_nob (.clk_i, .arst_n_i, .port_a_pin_i(pa),
        .port_b_pin_i(pb), .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o(rdata_nob),
        .shared_change_flag_o(flag_nob), .irq_o(irq_nob));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input pced_addr_t a, input pced_byte_t d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd_chk(input pced_addr_t a, input pced_byte_t exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, exp);
        chk(rdata_nob, (a >= 4'h3 && a <= 4'h5) ? 8'h00 : exp);
    endtask
    task automatic pulse(input logic [5:0] a, input logic [3:0] b);
        pins.drive(a, b);
        repeat (4) @(posedge clk_i);
    endtask
    task automatic outs(input logic [7:0] exp);
        repeat (2) @(posedge clk_i);
        #1 chk({6'h00, irq_o, shared_change_flag_o}, exp);
        chk({6'h00, irq_nob, flag_nob}, exp);
    endtask
    task automatic print_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_i);
        fails++;
        print_verdict();
    end
    initial
    begin
        repeat (16) @(posedge clk_i);
        arst_n_i <= 1'b1;
        for (int i = 0; i < 10; i++) rd_chk(i == 9 ? 4'hf : 4'(i), 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            wr(4'(i), 8'hff);
            rd_chk(4'(i), i < 3 ? 8'h3f : 8'hf0);
        end
        wr(4'hf, 8'hff);
        rd_chk(4'hf, 8'h00);
        wr(4'h2, 8'h00);
        wr(4'h5, 8'h00);
        wr(4'h1, 8'h00);
        wr(4'h4, 8'h00);
        rd_chk(4'h2, 8'h00);
        outs(8'h00);
        $display("test registers done");
        pulse(6'h15, 4'ha);
        rd_chk(4'h2, 8'h15);
        rd_chk(4'h5, 8'ha0);
        outs(8'h01);
        pulse(6'h00, 4'h0);
        rd_chk(4'h2, 8'h15);
        wr(4'h2, 8'h00);
        wr(4'h5, 8'h00);
        wr(4'h0, 8'h00);
        wr(4'h3, 8'h00);
        wr(4'h1, 8'h3f);
        wr(4'h4, 8'hf0);
        pulse(6'h3f, 4'hf);
        pulse(6'h15, 4'h5);
        rd_chk(4'h2, 8'h2a);
        rd_chk(4'h5, 8'ha0);
        $display("test edges done");
        wr(4'h8, 8'h03);
        wr(4'h6, 8'h01);
        outs(8'h03);
        wr(4'h7, 8'h01);
        wr(4'h8, 8'h01);
        outs(8'h01);
        wr(4'h7, 8'h02);
        rd_chk(4'h7, 8'h00);
        wr(4'h2, 8'h00);
        wr(4'h5, 8'h00);
        outs(8'h00);
        $display("test interrupt done");
        pins.drive(6'h00, 4'h5);
        @(posedge clk_i);
        wr(4'h2, 8'h00);
        rd_chk(4'h2, 8'h15);
        arst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        arst_n_i <= 1'b1;
        rd_chk(4'h2, 8'h00);
        rd_chk(4'h1, 8'h00);
        $display("test clear race and reset done");
        print_verdict();
    end
endmodule // tb_pin_change_edge_detector
bind pced_top pced_properties u_props (.clk_i, .arst_n_i, .port_a_pin_i, .port_b_pin_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .shared_change_flag_o, .irq_o);
